/* File: common/aacp_pkg.sv */
// constants for the ambient adc parameter bank and its visible sequencer
// assumes an apb master on pclk at 100 MHz; adc clock base period 50 ns
package aacp_pkg;
  localparam logic [11:0] AACP_OFS_IR_SEL = 12'h00e;
  localparam logic [11:0] AACP_OFS_AUX_SEL = 12'h00f;
  localparam logic [11:0] AACP_OFS_REC = 12'h010;
  localparam logic [11:0] AACP_OFS_GAIN = 12'h011;
  localparam logic [11:0] AACP_OFS_RANGE = 12'h012;
  localparam logic [11:0] AACP_OFS_CTRL = 12'h020;
  localparam logic [11:0] AACP_OFS_STATUS = 12'h024;
  localparam logic [7:0] AACP_RST_IR_SEL = 8'h00;
  localparam logic [7:0] AACP_RST_AUX_SEL = 8'h65;
  localparam logic [7:0] AACP_RST_REC = 8'h70;
  localparam logic [7:0] AACP_RST_GAIN = 8'h00;
  localparam logic [7:0] AACP_RST_RANGE = 8'h00;
  localparam logic [7:0] AACP_IR_SMALL = 8'h00;
  localparam logic [7:0] AACP_IR_LARGE = 8'h03;
  localparam logic [7:0] AACP_AUX_TEMP = 8'h65;
  localparam logic [7:0] AACP_AUX_VDD = 8'h75;
  localparam int AACP_REC_LSB = 4;
  localparam int AACP_RANGE_BIT = 5;
  localparam logic [7:0] AACP_REC_MASK = 8'h70;
  localparam logic [7:0] AACP_GAIN_MASK = 8'h07;
  localparam logic [7:0] AACP_RANGE_MASK = 8'h20;
  localparam int AACP_CLK_MHZ = 100;
  localparam int AACP_ADC_BASE_NS = 50;
  localparam int AACP_ADC_DIV = (AACP_ADC_BASE_NS * AACP_CLK_MHZ) / 1000;
  localparam int AACP_INT_CLOCKS = 16;
  typedef enum logic [1:0] {AACP_IDLE, AACP_RECOVER, AACP_INTEGRATE} aacp_state_t;
endpackage : aacp_pkg

/* File: verilog/aacp_adc_tick.sv */
// adc clock enable: base tick every 50 ns, then divided by 2^gain
// assumes gain stays steady while a conversion runs
`timescale 1ns/100ps
module aacp_adc_tick
  import aacp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] gain,
  output logic tick
);
  logic [2:0] base_cnt;
  logic [6:0] div_cnt;
  logic base;
  assign base = (base_cnt == 3'(AACP_ADC_DIV - 1));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      base_cnt <= 3'h0;
    else if (!run || base)
      base_cnt <= 3'h0;
    else
      base_cnt <= base_cnt + 3'h1;
  end
  // divide by 2^gain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 7'h00;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      div_cnt <= 7'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (base)
      begin
        if (div_cnt == ((7'h01 << gain) - 7'h01))
        begin
          div_cnt <= 7'h00;
          tick <= 1'b1;
        end
        else
          div_cnt <= div_cnt + 7'h01;
      end
    end
  end
endmodule : aacp_adc_tick

/* File: verilog/aacp_bank.sv */
// parameter bank with apb slave and visible-channel conversion sequencer
// assumes synchronous apb master on pclk; adc front end is outside
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
module aacp_bank
  import aacp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] ir_ambient_input_select,
  output logic [7:0] auxiliary_input_select,
  output logic aux_ground_reference,
  output logic [2:0] visible_gain_exponent,
  output logic visible_high_range_select,
  output logic adc_clock_enable,
  output logic vis_recovering,
  output logic vis_integrating,
  output logic vis_done
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] rec_reg;
  logic [7:0] gain_reg;
  logic [7:0] range_reg;
  logic [7:0] ir_reg;
  logic [7:0] aux_reg;
  logic start;
  logic busy;
  logic [15:0] conv_count;
  aacp_state_t state;
  logic [9:0] wait_cnt;
  logic tick;
  logic wr;
  logic rd;
  logic [31:0] next_prdata;
  logic next_err;

  function automatic logic [9:0] rec_clocks(input logic [2:0] code);
    // 000 gives 1, else 2^(code+2)-1; sum kept 4 bits so code 7 cannot wrap
    rec_clocks = (code == 3'h0) ? 10'h001
      : ((10'h001 << (4'(code) + 4'h2)) - 10'h001);
  endfunction : rec_clocks

  // offsets are word indexes; one aligned word per register
  function automatic logic [11:0] badr(input logic [11:0] ofs);
    badr = {ofs[9:0], 2'b00};
  endfunction : badr

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == badr(AACP_OFS_IR_SEL)) || (a == badr(AACP_OFS_AUX_SEL))
      || (a == badr(AACP_OFS_REC)) || (a == badr(AACP_OFS_GAIN))
      || (a == badr(AACP_OFS_RANGE)) || (a == badr(AACP_OFS_CTRL))
      || (a == badr(AACP_OFS_STATUS));
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // bus answers in the access cycle: no wait states
  assign wr = psel && penable && pwrite && mapped(paddr);
  assign rd = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_reg <= AACP_RST_IR_SEL;
      aux_reg <= AACP_RST_AUX_SEL;
      rec_reg <= AACP_RST_REC;
      gain_reg <= AACP_RST_GAIN;
      range_reg <= AACP_RST_RANGE;
    end
    else if (wr)
    begin
      case (paddr)
        badr(AACP_OFS_IR_SEL): ir_reg <= pwdata[7:0];
        badr(AACP_OFS_AUX_SEL): aux_reg <= pwdata[7:0];
        // reserved bits held at zero whatever is written
        badr(AACP_OFS_REC): rec_reg <= pwdata[7:0] & AACP_REC_MASK;
        badr(AACP_OFS_GAIN): gain_reg <= pwdata[7:0] & AACP_GAIN_MASK;
        badr(AACP_OFS_RANGE): range_reg <= pwdata[7:0] & AACP_RANGE_MASK;
        default: ;
      endcase
    end
  end

  assign start = wr && (paddr == badr(AACP_OFS_CTRL)) && pwdata[0] && !busy;

  always_comb
  begin
    next_err = psel && !penable && !mapped(paddr);
    case (paddr)
      badr(AACP_OFS_IR_SEL): next_prdata = {24'h00_0000, ir_reg};
      badr(AACP_OFS_AUX_SEL): next_prdata = {24'h00_0000, aux_reg};
      badr(AACP_OFS_REC): next_prdata = {24'h00_0000, rec_reg};
      badr(AACP_OFS_GAIN): next_prdata = {24'h00_0000, gain_reg};
      badr(AACP_OFS_RANGE): next_prdata = {24'h00_0000, range_reg};
      badr(AACP_OFS_STATUS): next_prdata = {conv_count, 14'h0000, busy, 1'b0};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      prdata <= rd ? next_prdata : 32'h0000_0000;
      pslverr <= next_err;
      pready <= psel && !penable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration driven to the adc front end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_ambient_input_select <= AACP_RST_IR_SEL;
      auxiliary_input_select <= AACP_RST_AUX_SEL;
      aux_ground_reference <= 1'b0;
      visible_gain_exponent <= AACP_RST_GAIN[2:0];
      visible_high_range_select <= AACP_RST_RANGE[AACP_RANGE_BIT];
    end
    else
    begin
      aux_ground_reference <= 1'b1;
      // copies load at the write edge itself, the same edge as the bank registers
      if (wr && (paddr == badr(AACP_OFS_IR_SEL)))
        ir_ambient_input_select <= pwdata[7:0];
      if (wr && (paddr == badr(AACP_OFS_AUX_SEL)))
        auxiliary_input_select <= pwdata[7:0];
      if (wr && (paddr == badr(AACP_OFS_GAIN)))
        visible_gain_exponent <= pwdata[2:0];
      if (wr && (paddr == badr(AACP_OFS_RANGE)))
        visible_high_range_select <= pwdata[AACP_RANGE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // visible conversion: recovery wait then integration, both on the
  // divided adc clock so gain stretches both; gain writes still land while busy
  assign busy = (state != AACP_IDLE);

  aacp_adc_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(busy),
    .gain(gain_reg[2:0]),
    .tick(tick)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= AACP_IDLE;
      wait_cnt <= 10'h000;
      conv_count <= 16'h0000;
    end
    else
    begin
      case (state)
        AACP_IDLE:
        begin
          if (start)
          begin
            state <= AACP_RECOVER;
            wait_cnt <= rec_clocks(rec_reg[AACP_REC_LSB +: 3]);
          end
        end
        AACP_RECOVER:
        begin
          if (tick)
          begin
            if (wait_cnt == 10'h001)
            begin
              state <= AACP_INTEGRATE;
              wait_cnt <= 10'(AACP_INT_CLOCKS);
            end
            else
              wait_cnt <= wait_cnt - 10'h001;
          end
        end
        AACP_INTEGRATE:
        begin
          if (tick)
          begin
            if (wait_cnt == 10'h001)
            begin
              state <= AACP_IDLE;
              conv_count <= conv_count + 16'h0001;
            end
            else
              wait_cnt <= wait_cnt - 10'h001;
          end
        end
        default: state <= AACP_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adc_clock_enable <= 1'b0;
      vis_recovering <= 1'b0;
      vis_integrating <= 1'b0;
      vis_done <= 1'b0;
    end
    else
    begin
      adc_clock_enable <= tick;
      vis_recovering <= (state == AACP_RECOVER);
      vis_integrating <= (state == AACP_INTEGRATE);
      vis_done <= (state == AACP_INTEGRATE) && tick && (wait_cnt == 10'h001);
    end
  end
endmodule : aacp_bank

/* File: sim/aacp_bank_props.sv */
// assertions on the parameter bank ports: register copies, apb answer, adc tick spacing
// assumes one pclk domain and the zero-wait apb answer of the bank
`timescale 1ns/100ps
module aacp_bank_props
  import aacp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [7:0] ir_ambient_input_select,
  input wire logic [7:0] auxiliary_input_select,
  input wire logic aux_ground_reference,
  input wire logic [2:0] visible_gain_exponent,
  input wire logic visible_high_range_select,
  input wire logic adc_clock_enable,
  input wire logic vis_recovering,
  input wire logic vis_integrating
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pwrite;
  ////////////////////////////////////////////////////////////////
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("no ready in access cycle");
  ir_copy_a: assert property (
    wr && paddr == {AACP_OFS_IR_SEL[9:0], 2'b00}
      |=> ir_ambient_input_select == $past(pwdata[7:0]))
    else $error("ir select not updated");
  aux_copy_a: assert property (
    wr && paddr == {AACP_OFS_AUX_SEL[9:0], 2'b00}
      |=> auxiliary_input_select == $past(pwdata[7:0]))
    else $error("aux select not updated");
  aux_ground_a: assert property ($past(presetn) |-> aux_ground_reference)
    else $error("aux not ground referenced");
  gain_copy_a: assert property (
    wr && paddr == {AACP_OFS_GAIN[9:0], 2'b00} |=> visible_gain_exponent == $past(pwdata[2:0]))
    else $error("gain not updated");
  range_copy_a: assert property (
    wr && paddr == {AACP_OFS_RANGE[9:0], 2'b00}
      |=> visible_high_range_select == $past(pwdata[5]))
    else $error("range bit not updated");
  // fastest divide (gain 0) still leaves four idle cycles between ticks
  tick_gap_a: assert property (adc_clock_enable |=> !adc_clock_enable [*4])
    else $error("adc ticks too close");
  phase_excl_a: assert property (!(vis_recovering && vis_integrating))
    else $error("recovery and integration overlap");
endmodule : aacp_bank_props

bind aacp_bank aacp_bank_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .ir_ambient_input_select(ir_ambient_input_select), .adc_clock_enable(adc_clock_enable),
  .auxiliary_input_select(auxiliary_input_select), .aux_ground_reference(aux_ground_reference),
  .visible_gain_exponent(visible_gain_exponent), .vis_integrating(vis_integrating),
  .visible_high_range_select(visible_high_range_select), .vis_recovering(vis_recovering));

/* File: sim/testbench.sv */
// self-checking bench for the parameter bank: apb registers and visible conversions
// assumes aacp_bank on a 100 MHz pclk with the checker bound to it
`timescale 1ns/100ps
module testbench
  import aacp_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, gnd_ref, hi_range, tick, recov, integ, done;
  logic [7:0] ir_sel, aux_sel;
  logic [2:0] gain;
  int err_count = 0, check_count = 0;
  integer seed = 32'hadb1_8a83;
  logic [11:0] regs [5] = '{AACP_OFS_IR_SEL, AACP_OFS_AUX_SEL, AACP_OFS_REC, AACP_OFS_GAIN,
    AACP_OFS_RANGE};
  logic [7:0] rstv [5] = '{8'h00, 8'h65, 8'h70, 8'h00, 8'h00};
  logic [7:0] msk [5] = '{8'hff, 8'hff, 8'h70, 8'h07, 8'h20};
  logic [7:0] mdl [5];
  aacp_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ir_ambient_input_select(ir_sel), .auxiliary_input_select(aux_sel),
    .aux_ground_reference(gnd_ref), .visible_gain_exponent(gain),
    .visible_high_range_select(hi_range), .adc_clock_enable(tick), .vis_recovering(recov),
    .vis_integrating(integ), .vis_done(done));
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic er);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a[9:0], 2'b00, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  function automatic int rec_clocks(input int r);
    return r == 0 ? 1 : (1 << (r + 2)) - 1;
  endfunction : rec_clocks
  task automatic conv(input int r, input int g);
    logic [31:0] rd;
    logic er;
    int ticks, t0, gap, n;
    apb(1'b1, AACP_OFS_REC, 32'(r << 4), rd, er);
    apb(1'b1, AACP_OFS_GAIN, 32'(g), rd, er);
    apb(1'b1, AACP_OFS_CTRL, 32'h0000_0001, rd, er);
    {ticks, t0, gap, n} = '0;
    while (done !== 1'b1 && n < 40000)
    begin
      @(posedge pclk);
      #1;
      n++;
      if (tick === 1'b1)
      begin
        if (ticks == 1) gap = n - t0;
        t0 = n;
        ticks++;
      end
    end
    if (n >= 40000) err_count++;
    chk("gain out", gain, 32'(g));
    chk("tick count", ticks, rec_clocks(r) + AACP_INT_CLOCKS);
    chk("tick period", gap, 5 << g);
  endtask : conv
  task finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #500_000;
    err_count++;
    finish_test();
  end
  initial
  begin
    logic [31:0] rd, d;
    logic er;
    int i;
    repeat (12) @(posedge pclk);
    chk("aux at reset", aux_sel, 8'h65);
    presetn <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b0, regs[k], 32'h0, rd, er);
      chk("reset value", rd, rstv[k]);
      mdl[k] = rstv[k];
    end
    chk("ground ref", gnd_ref, 1'b1);
    for (int k = 0; k < 30; k++)
    begin
      i = k < 4 ? k / 2 : $unsigned($random(seed)) % 5;
      d = k < 4 ? {8'h75, 8'h65, 8'h03, 8'h00} >> (8 * k) : $random(seed);
      d = d & msk[i];
      mdl[i] = d[7:0];
      apb(1'b1, regs[i], d, rd, er);
      apb(1'b0, regs[i], 32'h0, rd, er);
      chk("readback", rd, d);
      chk("ir out", ir_sel, mdl[0]);
      chk("aux out", aux_sel, mdl[1]);
      chk("gain out", gain, mdl[3][2:0]);
      chk("range out", hi_range, mdl[4][5]);
    end
    apb(1'b1, 12'h0ff, 32'h0000_00ff, rd, er);
    apb(1'b0, 12'h0ff, 32'h0, rd, er);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    chk("ir kept", ir_sel, mdl[0]);
    conv(0, 0);
    conv(6, 1);
    conv(1, 2);
    conv(7, 0);
    finish_test();
  end
endmodule : testbench
